// ---- hdl/scrr_bank.sv ----
// Purpose: read-side register bank of one channel
// Assumes: synchronous reset, one clock, strobes one cycle long
// Notes: external status inputs come from core logic not in this block
//
// Decided for this implementation: the address map and the plain strobed port.
`include "scrr_params.svh"

// Notes on behaviour
// - Interrupt-pending view only in channel A; channel B reads zero.
// - Two unused interrupt-pending bits read zero.
// - Pointer 4 gives written misc parameters if extended read, else ext status.
// - Pointer 5 gives written tx control if extended read, else special rx status.
// - Pointer 6 gives count low byte if FIFO enabled, else vector.
// - Pointer 7 gives count upper six bits if FIFO enabled, else pending view.
// - Pointer 7 top bits: overflow in D7, data available in D6.
// - Data available is one when FIFO holds entries, zero when empty.
// - Overflow sticks; cleared with FIFO only by disabling then enabling.
// - Pointer 9 gives written rx control if extended read, else pointer 13.
// - Unused misc status bits read zero.
// - Bit 7 one-missing clock latched in FM; zero in NRZI or PLL off.
// - Bit 6 two-missing clock latched in FM; same clears and forcing.
// - Bit 4 loop sending only while transmitting in SDLC loop mode.
// - Bit 1 on loop in SDLC loop, or X21 once transmitter active.
// - Pointer 11 gives written misc control if extended read, else pointer 15.
// - Pointer 12 returns time constant low byte.
// - Pointer 13 returns time constant high byte.
// - Pointer 14 gives ext feature if extended read, else misc status.
// - Pointer 15 returns interrupt enables, unused bits zero.
// - Enhanced features off after reset; enabled only by software.
// - Ext feature bit 6 is extended read enable.
// - Pointer 7 writes go to ext feature while enable bit D0 set.
module scrr_bank (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register port
    input wire scrr_pkg::scrr_bus_type i_bus,
    output logic [7:0] o_rdata,
    // Channel identity
    input wire logic i_chan_a,
    // Core status images
    input wire logic [7:0] i_ext_status,
    input wire logic [7:0] i_special_rx,
    input wire logic [7:0] i_vector,
    input wire logic [7:0] i_irq_pending,
    input wire logic [7:0] i_rx_data,
    // Status FIFO push at frame end
    input wire logic i_frame_push,
    input wire scrr_pkg::scrr_frame_type i_frame,
    input wire logic i_frame_pop,
    // Line and pll status
    input wire scrr_pkg::scrr_line_type i_line,
    // Written values to core
    output logic [7:0] o_ext_feature,
    output logic [7:0] o_sync_reg,
    output logic [15:0] o_time_const,
    output logic o_fifo_en
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] rx_control;
        logic [7:0] misc_param;
        logic [7:0] tx_control;
        logic [7:0] sync;
        logic [7:0] ext_feature;
        logic [7:0] misc_control;
        logic [7:0] tc_low;
        logic [7:0] tc_high;
        logic [7:0] ie;
        logic [`SCRR_FIFO_DEPTH-1:0][13:0] fifo;
        logic [3:0] wptr;
        logic [3:0] rptr;
        logic [4:0] used;
        logic overflow;
        logic miss_one;
        logic miss_two;
        logic miss_prev;
        logic [7:0] rdata;
    } scrr_state_type;

    scrr_state_type st_ff;
    scrr_state_type nxt_st;
    logic ext_read;
    logic fifo_on;
    logic pll_valid;
    logic [7:0] misc_status;
    logic [7:0] pend_view;
    logic [13:0] top_count;
    logic [7:0] rd_mux;

    // ----------------------------------------------------------------
    // Derived views
    // ----------------------------------------------------------------
    assign ext_read = st_ff.ext_feature[`SCRR_EXT_READ_BIT];
    assign fifo_on = st_ff.ie[`SCRR_FIFO_EN_BIT];
    assign pll_valid = i_line.fm_mode && i_line.pll_on;
    // Channel B has no pending register
    assign pend_view = i_chan_a ? (i_irq_pending & `SCRR_IRQ_PEND_MASK)
                                : `SCRR_RESET_BYTE;
    assign misc_status = {st_ff.miss_one && pll_valid,
                          st_ff.miss_two && pll_valid,
                          1'b0,
                          i_line.loop_sdlc && i_line.tx_sending,
                          2'b00,
                          i_line.loop_sdlc || (i_line.loop_x21 && i_line.tx_active),
                          1'b0};
    assign top_count = st_ff.fifo[st_ff.rptr];

    // ----------------------------------------------------------------
    // Read multiplexer
    // ----------------------------------------------------------------
    always_comb begin
        unique case (i_bus.ptr)
            `SCRR_RD_EXT_STATUS: rd_mux = i_ext_status;
            `SCRR_RD_SPECIAL_RX: rd_mux = i_special_rx;
            `SCRR_RD_VECTOR: rd_mux = i_vector;
            `SCRR_RD_IRQ_PENDING: rd_mux = pend_view;
            `SCRR_RD_MISC_PARAM: rd_mux = ext_read ? st_ff.misc_param : i_ext_status;
            `SCRR_RD_TX_CONTROL: rd_mux = ext_read ? st_ff.tx_control : i_special_rx;
            `SCRR_RD_FCOUNT_LOW: rd_mux = fifo_on ? top_count[7:0] : i_vector;
            // Overflow D7, data available D6, per the prose layout
            `SCRR_RD_FCOUNT_HIGH: rd_mux = fifo_on
                ? {st_ff.overflow, (st_ff.used != 5'h00), top_count[13:8]}
                : pend_view;
            `SCRR_RD_RX_DATA: rd_mux = i_rx_data;
            `SCRR_RD_RX_CONTROL: rd_mux = ext_read ? st_ff.rx_control : st_ff.tc_high;
            `SCRR_RD_MISC_STATUS: rd_mux = misc_status;
            `SCRR_RD_MISC_CONTROL: rd_mux = ext_read ? st_ff.misc_control
                                                     : (st_ff.ie & `SCRR_IE_MASK);
            `SCRR_RD_TC_LOW: rd_mux = st_ff.tc_low;
            `SCRR_RD_TC_HIGH: rd_mux = st_ff.tc_high;
            `SCRR_RD_EXT_FEATURE: rd_mux = ext_read ? st_ff.ext_feature : misc_status;
            `SCRR_RD_EXT_STATUS_IE: rd_mux = st_ff.ie & `SCRR_IE_MASK;
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdata = i_bus.rd ? rd_mux : `SCRR_RESET_BYTE;
        if (i_bus.wr) begin
            unique case (i_bus.ptr)
                `SCRR_WR_RX_CONTROL: nxt_st.rx_control = i_bus.wdata;
                `SCRR_WR_MISC_PARAM: nxt_st.misc_param = i_bus.wdata;
                `SCRR_WR_TX_CONTROL: nxt_st.tx_control = i_bus.wdata;
                `SCRR_WR_SYNC_OR_EXT: begin
                    if (st_ff.ie[`SCRR_EXT_SEL_BIT]) begin
                        nxt_st.ext_feature = i_bus.wdata;
                    end else begin
                        nxt_st.sync = i_bus.wdata;
                    end
                end
                `SCRR_WR_MISC_CONTROL: nxt_st.misc_control = i_bus.wdata;
                `SCRR_WR_TC_LOW: nxt_st.tc_low = i_bus.wdata;
                `SCRR_WR_TC_HIGH: nxt_st.tc_high = i_bus.wdata;
                `SCRR_WR_EXT_STATUS_IE: nxt_st.ie = i_bus.wdata;
                default: begin
                end
            endcase
        end
        // Missing clock tracking; set wins over a same-cycle clear
        if (i_line.clr_miss) begin
            nxt_st.miss_one = 1'b0;
            nxt_st.miss_two = 1'b0;
            nxt_st.miss_prev = 1'b0;
        end
        if (pll_valid && i_line.edge_miss) begin
            nxt_st.miss_one = 1'b1;
            nxt_st.miss_prev = 1'b1;
            if (st_ff.miss_prev) begin
                nxt_st.miss_two = 1'b1;
            end
        end else if (pll_valid && !i_line.clr_miss) begin
            nxt_st.miss_prev = 1'b0;
        end
        // Status FIFO; pop on i_frame_pop unless a read of a pointer other than special rx is in the same cycle
        if (fifo_on) begin
            if (i_frame_pop && st_ff.used != 5'h00
                && !(i_bus.rd && i_bus.ptr != `SCRR_RD_SPECIAL_RX)) begin
                nxt_st.rptr = (st_ff.rptr == 4'h9) ? 4'h0 : st_ff.rptr + 4'h1;
                nxt_st.used = st_ff.used - 5'h01;
            end
            if (i_frame_push) begin
                if (nxt_st.used == 5'(`SCRR_FIFO_DEPTH)) begin
                    nxt_st.overflow = 1'b1;
                end else begin
                    nxt_st.fifo[st_ff.wptr] = i_frame.count;
                    nxt_st.wptr = (st_ff.wptr == 4'h9) ? 4'h0 : st_ff.wptr + 4'h1;
                    nxt_st.used = nxt_st.used + 5'h01;
                end
            end
        end else begin
            // Disabling empties FIFO and clears overflow
            nxt_st.fifo = '0;
            nxt_st.wptr = 4'h0;
            nxt_st.rptr = 4'h0;
            nxt_st.used = 5'h00;
            nxt_st.overflow = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_rdata = st_ff.rdata;
    assign o_ext_feature = st_ff.ext_feature;
    assign o_sync_reg = st_ff.sync;
    assign o_time_const = {st_ff.tc_high, st_ff.tc_low};
    assign o_fifo_en = fifo_on;
endmodule : scrr_bank

// ---- hdl/scrr_params.svh ----
// Purpose: constants for the serial channel read-register bank
// Assumes: register pointer is 4 bits, data 8 bits
// Notes: pointer values double as read/write indices
`ifndef SCRR_PARAMS_SVH
`define SCRR_PARAMS_SVH
// --------------------------------------------------------------------
// Read pointers
// --------------------------------------------------------------------
`define SCRR_RD_EXT_STATUS 4'h0
`define SCRR_RD_SPECIAL_RX 4'h1
`define SCRR_RD_VECTOR 4'h2
`define SCRR_RD_IRQ_PENDING 4'h3
`define SCRR_RD_MISC_PARAM 4'h4
`define SCRR_RD_TX_CONTROL 4'h5
`define SCRR_RD_FCOUNT_LOW 4'h6
`define SCRR_RD_FCOUNT_HIGH 4'h7
`define SCRR_RD_RX_DATA 4'h8
`define SCRR_RD_RX_CONTROL 4'h9
`define SCRR_RD_MISC_STATUS 4'hA
`define SCRR_RD_MISC_CONTROL 4'hB
`define SCRR_RD_TC_LOW 4'hC
`define SCRR_RD_TC_HIGH 4'hD
`define SCRR_RD_EXT_FEATURE 4'hE
`define SCRR_RD_EXT_STATUS_IE 4'hF
// --------------------------------------------------------------------
// Write pointers
// --------------------------------------------------------------------
`define SCRR_WR_RX_CONTROL 4'h3
`define SCRR_WR_MISC_PARAM 4'h4
`define SCRR_WR_TX_CONTROL 4'h5
`define SCRR_WR_SYNC_OR_EXT 4'h7
`define SCRR_WR_MISC_CONTROL 4'hA
`define SCRR_WR_TC_LOW 4'hC
`define SCRR_WR_TC_HIGH 4'hD
`define SCRR_WR_EXT_STATUS_IE 4'hF
// --------------------------------------------------------------------
// Fields and reset values
// --------------------------------------------------------------------
`define SCRR_EXT_READ_BIT 6
`define SCRR_FIFO_EN_BIT 2
`define SCRR_EXT_SEL_BIT 0
`define SCRR_IRQ_PEND_MASK 8'h3F
`define SCRR_IE_MASK 8'hFB
`define SCRR_RESET_BYTE 8'h00
`define SCRR_FIFO_DEPTH 10
`endif

// ---- hdl/scrr_pkg.sv ----
// Purpose: types for the serial channel read-register bank
// Assumes: params header defines all numbers
// Notes: none
package scrr_pkg;
    typedef struct packed {
        logic [13:0] count;
    } scrr_frame_type;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] ptr;
        logic [7:0] wdata;
    } scrr_bus_type;
    typedef struct packed {
        logic fm_mode;
        logic pll_on;
        logic edge_miss;
        logic clr_miss;
        logic loop_sdlc;
        logic loop_x21;
        logic tx_sending;
        logic tx_active;
    } scrr_line_type;
endpackage : scrr_pkg

// ---- test/scrr_bank_monitor.sv ----
// Purpose: checker on the read-register bank ports
// Assumes: one clock, sync reset active high
// Notes: bound to every scrr_bank
module scrr_bank_monitor (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register port
    input wire scrr_pkg::scrr_bus_type i_bus,
    input wire logic [7:0] o_rdata,
    // Status and written values
    input wire logic i_chan_a,
    input wire logic [7:0] i_ext_status,
    input wire logic [7:0] i_vector,
    input wire logic [7:0] o_ext_feature,
    input wire logic [15:0] o_time_const,
    input wire logic o_fifo_en
);
    default clocking dc @(posedge i_clk); endclocking
    default disable iff (i_rst);
    tc_low_a: assert property (i_bus.rd && i_bus.ptr == 4'hC |=>
        o_rdata == $past(o_time_const[7:0])) else $error("time constant low wrong");
    tc_high_a: assert property (i_bus.rd && i_bus.ptr == 4'hD |=>
        o_rdata == $past(o_time_const[15:8])) else $error("time constant high wrong");
    pend_chan_b_a: assert property (i_bus.rd && i_bus.ptr == 4'h3 && !i_chan_a |=>
        o_rdata == 8'h00) else $error("pending view not zero in channel b");
    pend_top_a: assert property (i_bus.rd && i_bus.ptr == 4'h3 |=>
        o_rdata[7:6] == 2'b00) else $error("pending unused bits set");
    param_mirror_a: assert property (i_bus.rd && i_bus.ptr == 4'h4 && !o_ext_feature[6] |=>
        o_rdata == $past(i_ext_status)) else $error("pointer 4 mirror wrong");
    vector_mirror_a: assert property (i_bus.rd && i_bus.ptr == 4'h6 && !o_fifo_en |=>
        o_rdata == $past(i_vector)) else $error("pointer 6 mirror wrong");
    feature_read_a: assert property (i_bus.rd && i_bus.ptr == 4'hE && o_ext_feature[6] |=>
        o_rdata == $past(o_ext_feature)) else $error("feature readback wrong");
    misc_unused_a: assert property (i_bus.rd && i_bus.ptr == 4'hA |=>
        (o_rdata & 8'h2D) == 8'h00) else $error("misc status unused bits set");
    // Main scenarios
    cover property (i_bus.rd && i_bus.ptr == 4'h7 && o_fifo_en);
    cover property (i_bus.rd && i_bus.ptr == 4'hE && o_ext_feature[6]);
    cover property (i_bus.rd && i_bus.ptr == 4'h3 && !i_chan_a);
endmodule : scrr_bank_monitor

bind scrr_bank scrr_bank_monitor scrr_bank_monitor_i (.i_clk(i_clk), .i_rst(i_rst),
    .i_bus(i_bus), .o_rdata(o_rdata), .i_chan_a(i_chan_a), .i_ext_status(i_ext_status),
    .i_vector(i_vector), .o_ext_feature(o_ext_feature), .o_time_const(o_time_const),
    .o_fifo_en(o_fifo_en));

// ---- test/tb.sv ----
// Purpose: self-checking bench for scrr_bank
// Assumes: read data one cycle after the read strobe
// Notes: status FIFO overflow needs eleven pushes
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_rst, i_chan_a, i_frame_push, i_frame_pop, o_fifo_en;
    scrr_pkg::scrr_bus_type i_bus;
    scrr_pkg::scrr_frame_type i_frame;
    scrr_pkg::scrr_line_type i_line;
    logic [7:0] i_ext_status, i_special_rx, i_vector, i_irq_pending, i_rx_data;
    logic [7:0] o_rdata, o_ext_feature, o_sync_reg;
    logic [15:0] o_time_const;
    int n_fail = 0;
    int checks = 0;
    scrr_bank scrr_bank_i (.i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
        .i_chan_a(i_chan_a), .i_ext_status(i_ext_status), .i_special_rx(i_special_rx),
        .i_vector(i_vector), .i_irq_pending(i_irq_pending), .i_rx_data(i_rx_data),
        .i_frame_push(i_frame_push), .i_frame(i_frame), .i_frame_pop(i_frame_pop),
        .i_line(i_line), .o_ext_feature(o_ext_feature), .o_sync_reg(o_sync_reg),
        .o_time_const(o_time_const), .o_fifo_en(o_fifo_en));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // --------------------------------------------------------------
    // Bus and status tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] p, input logic [7:0] d);
        @(posedge i_clk);
        i_bus <= '{1'b1, 1'b0, p, d};
        @(posedge i_clk);
        i_bus.wr <= 1'b0;
        // Let the write settle before any port compare
        #1;
    endtask : wr
    // Data only stands one cycle, so sample just after that edge
    task automatic rd(input logic [3:0] p, input logic [7:0] e);
        @(posedge i_clk);
        i_bus <= '{1'b0, 1'b1, p, 8'h00};
        @(posedge i_clk);
        i_bus.rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask : rd
    task automatic ln(input logic [7:0] v);
        @(posedge i_clk);
        i_line <= scrr_pkg::scrr_line_type'(v);
    endtask : ln
    task automatic fifo(input logic push, input logic [13:0] c);
        @(posedge i_clk);
        i_frame_push <= push;
        i_frame_pop <= !push;
        i_frame.count <= c;
        @(posedge i_clk);
        i_frame_push <= 1'b0;
        i_frame_pop <= 1'b0;
    endtask : fifo
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    // --------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------
    initial begin
        i_rst = 1'b1;
        i_bus = '0;
        i_frame = '0;
        i_line = '0;
        i_frame_push = 1'b0;
        i_frame_pop = 1'b0;
        i_chan_a = 1'b1;
        i_ext_status = 8'h81;
        i_special_rx = 8'h42;
        i_vector = 8'h17;
        i_irq_pending = 8'hFF;
        i_rx_data = 8'h6C;
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(4'hC, 8'h00);
        rd(4'hF, 8'h00);
        rd(4'hE, 8'h00);
        chk(o_ext_feature, 8'h00);
        rd(4'h8, 8'h6C);
        wr(4'hC, 8'h5A);
        wr(4'hD, 8'hA5);
        rd(4'hC, 8'h5A);
        rd(4'hD, 8'hA5);
        rd(4'h9, 8'hA5);
        rd(4'h4, 8'h81);
        rd(4'h5, 8'h42);
        rd(4'h6, 8'h17);
        rd(4'h3, 8'h3F);
        rd(4'h7, 8'h3F);
        wr(4'hF, 8'hC1);
        rd(4'hF, 8'hC1);
        rd(4'hB, 8'hC1);
        @(posedge i_clk);
        i_chan_a <= 1'b0;
        rd(4'h3, 8'h00);
        rd(4'h7, 8'h00);
        $display("test mirrors done");
        ln(8'hE0);
        ln(8'hC0);
        rd(4'hA, 8'h80);
        ln(8'hE0);
        ln(8'hE0);
        ln(8'hC0);
        rd(4'hA, 8'hC0);
        ln(8'hD0);
        ln(8'hC0);
        rd(4'hA, 8'h00);
        ln(8'h60);
        ln(8'h40);
        rd(4'hA, 8'h00);
        ln(8'h0A);
        rd(4'hA, 8'h12);
        ln(8'h05);
        rd(4'hE, 8'h02);
        ln(8'h04);
        rd(4'hA, 8'h00);
        $display("test misc status done");
        wr(4'h7, 8'h40);
        chk(o_ext_feature, 8'h40);
        wr(4'h3, 8'h33);
        wr(4'h4, 8'h44);
        wr(4'h5, 8'h55);
        wr(4'hA, 8'hAA);
        rd(4'h9, 8'h33);
        rd(4'h4, 8'h44);
        rd(4'h5, 8'h55);
        rd(4'hB, 8'hAA);
        rd(4'hE, 8'h40);
        wr(4'hF, 8'h00);
        wr(4'h7, 8'h12);
        chk(o_sync_reg, 8'h12);
        chk(o_ext_feature, 8'h40);
        $display("test extended read done");
        wr(4'hF, 8'h04);
        chk({7'h00, o_fifo_en}, 8'h01);
        rd(4'h7, 8'h00);
        fifo(1'b1, 14'h1234);
        rd(4'h7, 8'h52);
        rd(4'h6, 8'h34);
        fifo(1'b0, 14'h0000);
        rd(4'h7, 8'h00);
        for (int k = 0; k < 11; k++) fifo(1'b1, 14'h0100 + 14'(k));
        rd(4'h7, 8'hC1);
        rd(4'h6, 8'h00);
        wr(4'hF, 8'h00);
        wr(4'hF, 8'h04);
        rd(4'h7, 8'h00);
        $display("test status fifo done");
        give_verdict();
    end
    // Tests take well under a thousand cycles
    initial begin
        repeat (5000) @(posedge i_clk);
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        give_verdict();
    end
endmodule : tb
